// >>> hw/isoio_rack_port.sv
// Behaviour
// - answer four consecutive addresses of sixty-four
// - offsets zero to three select blocks zero-three
// - data bit n drives block channel n
// - block k holds rack channels 8k to 8k+7
// - board address is sum of ON switch weights
// - write latches byte, ones activate channels
// - read returns block state, outputs read back
// - each channel individually input or output
`timescale 1ns/1ns
`default_nettype none
module isoio_rack_port (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    // board address switches, one bit per weight, high = ON
    input  wire logic [5:0]  dip_switch_i,
    // channel direction, high = output module fitted
    input  wire logic [31:0] chan_is_output_i,
    // expansion bus from controller
    input  wire logic        address_pointer_port_wr_i,
    input  wire logic        data_transfer_port_wr_i,
    input  wire logic        data_transfer_port_rd_i,
    input  wire logic [5:0]  bus_data_i,
    input  wire logic [7:0]  bus_wdata_i,
    output logic      [7:0]  bus_rdata_o,
    output logic             bus_rdata_oe_n_o,
    // field side
    input  wire logic [31:0] chan_sense_i,
    output logic      [31:0] chan_drive_o
);
    // =========================================================
    // notes
    // - one system clock; field levels are the only inputs from outside it
    // - bus strobes are single-cycle pulses already timed to this clock
    // - a pointer load and a data access in the same cycle: the access
    //   uses the pointer held before that edge
    // - the write busy time after a data write is the controller's duty;
    //   this block accepts a new access on any cycle
    // - readback of an input channel lags its pin by about four cycles
    // - a rack window is four aligned addresses, so the two lowest
    //   switches take no part in the decode
    // - bus_rdata_o reads zero whenever the enable is high
    // - reset clears every latch, so all output modules start inactive
    // - a data access outside the window changes nothing here
    // - channel 8k+n of the rack is bit n of block k
    // - the direction map is a static strap; changing it live only
    //   changes what readback returns
    // - a read strobe held high keeps the byte on the bus, one cycle behind
    // - a field level between two disagreeing stages is held, not passed

    // =========================================================
    // field input synchronisers, one per channel
    logic [31:0] sense_s1_reg;
    logic [31:0] sense_s2_reg;
    logic [31:0] sense_s3_reg;
    logic [31:0] sense_reg;

    genvar gc;
    generate
        for (gc = 0; gc < 32; gc++) begin : g_sense
            // three stages guard against metastable field levels
            always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    sense_s1_reg[gc] <= isoio_pkg::OUT_RST[gc];
                    sense_s2_reg[gc] <= isoio_pkg::OUT_RST[gc];
                    sense_s3_reg[gc] <= isoio_pkg::OUT_RST[gc];
                end else begin
                    sense_s1_reg[gc] <= chan_sense_i[gc];
                    sense_s2_reg[gc] <= sense_s1_reg[gc];
                    sense_s3_reg[gc] <= sense_s2_reg[gc];
                end
            end

            // a new level counts only once the last two stages agree
            always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    sense_reg[gc] <= isoio_pkg::OUT_RST[gc];
                end else if (sense_s2_reg[gc] == sense_s3_reg[gc]) begin
                    sense_reg[gc] <= sense_s3_reg[gc];
                end
            end
        end
    endgenerate

    // =========================================================
    // board address, caught every clock after reset release
    // switches are static, so the one-cycle lag after release is harmless
    logic [5:0] board_addr_reg;

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            board_addr_reg <= isoio_pkg::PTR_RST;
        end else begin
            board_addr_reg <= dip_switch_i;
        end
    end

    // =========================================================
    // address pointer
    // the pointer keeps its value, so repeated accesses to one block need no reload
    logic [5:0] ptr_reg;

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ptr_reg <= isoio_pkg::PTR_RST;
        end else if (address_pointer_port_wr_i) begin
            ptr_reg <= bus_data_i;
        end
    end

    // =========================================================
    // decode helpers
    // true when the pointer falls inside this rack's four-address window
    function automatic logic hit(
        input logic [5:0] ptr,
        input logic [5:0] brd
    );
        hit = (ptr[isoio_pkg::BRD_SEL_LSB +: isoio_pkg::BRD_SEL_W]
               == brd[isoio_pkg::BRD_SEL_LSB +: isoio_pkg::BRD_SEL_W]);
    endfunction : hit

    // one-hot block enable from the low pointer bits
    function automatic logic [3:0] blk_onehot(
        input logic [1:0] idx
    );
        blk_onehot      = 4'h0;
        blk_onehot[idx] = 1'b1;
    endfunction : blk_onehot

    // =========================================================
    // access enables, one bit per block
    logic       sel;
    logic [1:0] blk;
    logic [3:0] wr_en;
    logic [3:0] rd_en;

    assign sel   = hit(ptr_reg, board_addr_reg);
    assign blk   = ptr_reg[isoio_pkg::BLK_IDX_LSB +: isoio_pkg::BLK_IDX_W];
    assign wr_en = (data_transfer_port_wr_i && sel) ? blk_onehot(blk) : 4'h0;
    assign rd_en = (data_transfer_port_rd_i && sel) ? blk_onehot(blk) : 4'h0;

    // =========================================================
    // output latches, one byte per block
    logic [31:0] drive_reg;

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_latch
            // writes to other blocks leave this byte alone
            always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    drive_reg[gb*8 +: 8] <= isoio_pkg::OUT_RST[gb*8 +: 8];
                end else if (wr_en[gb]) begin
                    drive_reg[gb*8 +: 8] <= bus_wdata_i;
                end
            end
        end
    endgenerate

    // the latches feed the module pins directly
    assign chan_drive_o = drive_reg;

    // =========================================================
    // channel state as seen by readback
    // output channels return their latch, input channels their filtered level
    logic [31:0] state_w;
    logic [7:0]  blk_byte_w [4];

    assign state_w = (chan_is_output_i & drive_reg) | (~chan_is_output_i & sense_reg);

    generate
        for (gb = 0; gb < 4; gb++) begin : g_byte
            assign blk_byte_w[gb] = state_w[gb*8 +: 8];
        end
    endgenerate

    // =========================================================
    // read byte select
    logic [7:0] rd_byte_w;

    always_comb begin
        rd_byte_w = isoio_pkg::RD_RST;
        // at most one enable bit is high, the loop picks it
        for (int b = 0; b < 4; b++) begin
            if (rd_en[b]) begin
                rd_byte_w = blk_byte_w[b];
            end
        end
    end

    // =========================================================
    // read data and enable; the bus floats whenever this rack is not read
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bus_rdata_o      <= isoio_pkg::RD_RST;
            bus_rdata_oe_n_o <= 1'b1;
        end else if (|rd_en) begin
            bus_rdata_o      <= rd_byte_w;
            bus_rdata_oe_n_o <= 1'b0;
        end else begin
            // zero rather than the last byte, so an idle bus shows nothing stale
            bus_rdata_o      <= isoio_pkg::RD_RST;
            bus_rdata_oe_n_o <= 1'b1;
        end
    end
endmodule : isoio_rack_port
`default_nettype wire

// >>> common/isoio_pkg.sv
package isoio_pkg;
    // =========================================================
    // bus geometry
    localparam int unsigned ADDR_W       = 6;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned BLOCKS       = 4;
    localparam int unsigned CHANNELS     = 32;
    localparam int unsigned BLK_IDX_W    = 2;
    localparam int unsigned BRD_SEL_W    = 4;
    // =========================================================
    // field positions in the bus address
    localparam int unsigned BRD_SEL_LSB  = 2;
    localparam int unsigned BLK_IDX_LSB  = 0;
    // =========================================================
    // reset values
    localparam logic [CHANNELS-1:0] OUT_RST  = 32'h0000_0000;
    localparam logic [ADDR_W-1:0]   PTR_RST  = 6'h00;
    localparam logic [DATA_W-1:0]   RD_RST   = 8'h00;
    // =========================================================
    // pin synchroniser depth
    localparam int unsigned SYNC_STAGES  = 3;
endpackage : isoio_pkg

// >>> verification/isoio_chk_checker.sv
`timescale 1ns/1ns
`default_nettype none
module isoio_chk (input wire logic core_clk_i, sys_rst_i, address_pointer_port_wr_i,
    data_transfer_port_wr_i, data_transfer_port_rd_i, bus_rdata_oe_n_o,
    input wire logic [5:0] dip_switch_i, bus_data_i, input wire logic [7:0] bus_wdata_i,
    bus_rdata_o, input wire logic [31:0] chan_is_output_i, chan_drive_o);
    logic [5:0] p_reg;
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
        if (sys_rst_i) p_reg <= 6'h00;
        else if (address_pointer_port_wr_i) p_reg <= bus_data_i;
    wire h = p_reg[5:2] == dip_switch_i[5:2], o = bus_rdata_oe_n_o;
    wire w = data_transfer_port_wr_i & h, r = data_transfer_port_rd_i & h;
    wire [4:0] s = {p_reg[1:0], 3'h0};
    wire [31:0] d = chan_drive_o, m = 32'h0000_00FF << s, k = d & ~m;
    wire [7:0] b = d[s+:8];
    wire a = &(chan_is_output_i | ~m);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_write_latch: assert property (w |=> d[$past(s)+:8] == $past(bus_wdata_i)) else $error("no latch");
    a_block_only: assert property (w |=> (d & ~$past(m)) == $past(k)) else $error("wrong block");
    a_miss_hold: assert property (!w |=> $stable(d)) else $error("drive moved");
    a_read_on: assert property (r |=> !o) else $error("no read");
    a_read_off: assert property (!r |=> o) else $error("bus driven");
    a_idle_zero: assert property (o |-> bus_rdata_o == 8'h00) else $error("idle data");
    a_read_back: assert property (r && a |=> bus_rdata_o == $past(b)) else $error("readback");
    a_reset_clear: assert property ($fell(sys_rst_i) |-> d == 32'h0 && o) else $error("reset");
endmodule : isoio_chk
bind isoio_rack_port isoio_chk u_chk (.*);
`default_nettype wire

// >>> verification/isoio_host.sv
`timescale 1ns/1ns
`default_nettype none
module isoio_host #(parameter int HOLD = 2500) (input wire logic core_clk_i, n, input wire logic [7:0] q,
    output logic pw, wr, rd, output logic [5:0] ad, output logic [7:0] wd);
    initial {pw, wr, rd, ad, wd} = '0;
    // released lines show the inverse of their last value
    task put(input logic [5:0] a, input logic [7:0] d);
        @(posedge core_clk_i) #1 {pw, ad} = {1'b1, a};
        @(posedge core_clk_i) #1 {pw, ad, wr, wd} = {1'b0, ~a, 1'b1, d};
        @(posedge core_clk_i) #1 {wr, wd} = {1'b0, ~d};
        repeat (HOLD) @(posedge core_clk_i);
    endtask : put
    task get(input logic [5:0] a, output logic [8:0] v);
        @(posedge core_clk_i) #1 {pw, ad} = {1'b1, a};
        @(posedge core_clk_i) #1 {pw, ad, rd} = {1'b0, ~a, 1'b1};
        @(posedge core_clk_i) #1 {v, rd} = {n, q, 1'b0};
    endtask : get
endmodule : isoio_host
`default_nettype wire

// >>> verification/isoio_rack_port_bench.sv
`timescale 1ns/1ns
`default_nettype none
module isoio_rack_port_bench;
    logic core_clk_i = 0, sys_rst_i = 1, address_pointer_port_wr_i, data_transfer_port_wr_i;
    logic data_transfer_port_rd_i, bus_rdata_oe_n_o;
    logic [5:0] dip_switch_i = 6'h14, bus_data_i;
    logic [7:0] bus_wdata_i, bus_rdata_o;
    logic [31:0] chan_is_output_i = '1, chan_sense_i = '0, chan_drive_o;
    logic [8:0] v;
    int n_mismatch, n_checks;
    always #2 core_clk_i = ~core_clk_i;
    isoio_rack_port dut (.*);
    isoio_host host (.core_clk_i, .n(bus_rdata_oe_n_o), .q(bus_rdata_o), .pw(address_pointer_port_wr_i),
        .wr(data_transfer_port_wr_i), .rd(data_transfer_port_rd_i), .ad(bus_data_i), .wd(bus_wdata_i));
    task chk(input string s, input logic [31:0] g, e);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : close_out
    task t_walk;
        host.put(6'h15, 8'h08);
        chk("drive", chan_drive_o, 32'h0000_0800);
        host.get(6'h15, v);
        chk("read", {23'h0, v}, 32'h0000_0008);
        $display("walk done");
    endtask : t_walk
    task t_span;
        for (int k = 0; k < 4; k++) host.put(6'h14 + 6'(k), 8'hA0 | 8'(k));
        host.put(6'h18, 8'hFF);
        host.put(6'h13, 8'hFF);
        chk("span", chan_drive_o, 32'hA3A2_A1A0);
        host.get(6'h18, v);
        chk("float", {23'h0, v}, 32'h0000_0100);
        $display("span done");
    endtask : t_span
    task t_mix;
        dip_switch_i = 6'h2C;
        chan_is_output_i = 32'hFFFF_FF0F;
        chan_sense_i = 32'h0000_00C0;
        host.put(6'h2C, 8'h5A);
        host.get(6'h2C, v);
        chk("mix", {23'h0, v}, 32'h0000_00CA);
        $display("mix done");
    endtask : t_mix
    initial begin
        repeat (5) @(posedge core_clk_i);
        #1 sys_rst_i = 0;
        chk("clear", chan_drive_o, 32'h0000_0000);
        chk("oe", {31'h0, bus_rdata_oe_n_o}, 32'h0000_0001);
        t_walk;
        t_span;
        t_mix;
        close_out;
    end
    initial begin
        // eight writes each wait 10 us of busy time, about 80 us in all
        #120000;
        n_mismatch++;
        close_out;
    end
endmodule : isoio_rack_port_bench
`default_nettype wire
